// ---- host_port.sv ----
// indirect-access host port: index pair, indirect data port and frame port
// assumes host strobes are held for several clocks; core side runs on CLOCK
`timescale 1ns/1ps
module host_port
  import host_port_pkg::*;
(
  input  wire logic               CLOCK,
  input  wire logic               RST,
  input  wire logic               WIDE_MODE,
  input  wire logic               HOST_CS_N,
  input  wire logic               HOST_RD_N,
  input  wire logic               HOST_WR_N,
  input  wire logic [HOST_AW-1:0] HOST_ADDR,
  input  wire logic [HOST_DW-1:0] HOST_DATA_I,
  output logic      [HOST_DW-1:0] HOST_DATA_O,
  output logic                    HOST_DATA_OE,
  output logic      [IND_AW-1:0]  IND_ADDR,
  output logic                    IND_WR,
  output logic                    IND_RD,
  output logic      [IND_DW-1:0]  IND_WDATA,
  input  wire logic [IND_DW-1:0]  IND_RDATA,
  output logic                    FRM_IN_VALID,
  output frame_beat_s             FRM_IN,
  input  wire logic               FRM_IN_READY,
  input  wire logic               FRM_OUT_VALID,
  input  wire frame_beat_s        FRM_OUT,
  output logic                    FRM_OUT_READY
);

  // advance a frame position; header size bytes are little-endian
  function automatic frame_pos_s frame_step(input frame_pos_s pos,
                                            input logic [HOST_DW-1:0] data,
                                            input logic wide);
    frame_pos_s        nxt;
    logic [FCNT_W-1:0] step;
    logic [FCNT_W-1:0] total;
    nxt  = pos;
    step = wide ? STEP_WIDE : STEP_NARROW;
    if (pos.count == SIZE_BYTE0) begin
      nxt.size = wide ? data : {pos.size[FCNT_W-1:8], data[7:0]};
    end else if (pos.count == SIZE_BYTE1 && !wide) begin
      nxt.size = {data[7:0], pos.size[7:0]};
    end
    total = HDR_BYTES + ((nxt.size + PAD_MASK) & ~PAD_MASK);
    // total drops below the header only when header plus padded size overflows 16 bits; otherwise both size bytes are in before a wrap
    if (pos.count + step >= total) begin
      nxt.count = CNT_RESET;
    end else begin
      nxt.count = pos.count + step;
    end
    return nxt;
  endfunction : frame_step

  // end flag derived from the positions both before and after the step is applied
  function automatic logic frame_ends(input frame_pos_s pos, input frame_pos_s nxt);
    return (nxt.count == CNT_RESET) && (pos.count != CNT_RESET || nxt.size != pos.size);
  endfunction : frame_ends

  // two-stage synchroniser for every host pin; reset to ones so the
  // strobes look idle and no false access edge follows reset
  host_pins_s pins_raw;
  host_pins_s sync1_q;
  host_pins_s sync2_q;
  host_pins_s prev_q;
  logic       mode1_q;
  logic       mode2_q;

  assign pins_raw = '{cs_n: HOST_CS_N, rd_n: HOST_RD_N, wr_n: HOST_WR_N,
                      addr: HOST_ADDR, wdata: HOST_DATA_I};

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      sync1_q <= '1;
      sync2_q <= '1;
      prev_q  <= '1;
      mode1_q <= 1'b0;
      mode2_q <= 1'b0;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
      mode1_q <= WIDE_MODE;
      mode2_q <= mode1_q;
    end
  end

  // access starts on the first synchronised cycle of an active strobe
  wire wr_now  = !sync2_q.cs_n && !sync2_q.wr_n;
  wire wr_was  = !prev_q.cs_n && !prev_q.wr_n;
  wire rd_now  = !sync2_q.cs_n && !sync2_q.rd_n;
  wire rd_was  = !prev_q.cs_n && !prev_q.rd_n;
  wire wr_go   = wr_now && !wr_was;
  wire rd_go   = rd_now && !rd_was;
  wire wide    = mode2_q;

  wire sel_low   = sync2_q.addr == OFS_ADDR_LOW;
  wire sel_high  = sync2_q.addr == OFS_ADDR_HIGH;
  wire sel_data  = sync2_q.addr == OFS_DATA_PORT;
  wire sel_frame = sync2_q.addr == OFS_FRAME;

  // low byte lane of the write data; the only lane used in narrow mode
  wire [IND_DW-1:0] wr_byte = sync2_q.wdata[IND_DW-1:0];

  // index registers; value persists until the next index write
  // a high-index write in wide mode falls through and changes nothing
  logic [IND_AW-1:0] index_q;
  logic [IND_AW-1:0] index_d;

  assign index_d = !wr_go ? index_q :
                   (sel_low && wide)   ? sync2_q.wdata :
                   (sel_low && !wide)  ? {index_q[IND_AW-1:IND_DW], wr_byte} :
                   (sel_high && !wide) ? {wr_byte, index_q[IND_DW-1:0]} :
                   index_q;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) index_q <= ADDR_RESET;
    else     index_q <= index_d;
  end

  // indirect data port strobes towards the register space
  // read data is captured one clock after the strobe, when the register space answers
  logic              ind_wr_q;
  logic              ind_rd_q;
  logic              ind_cap_q;
  logic [IND_DW-1:0] ind_wdata_q;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ind_wr_q    <= 1'b0;
      ind_rd_q    <= 1'b0;
      ind_cap_q   <= 1'b0;
      ind_wdata_q <= '0;
    end else begin
      ind_wr_q    <= wr_go && sel_data;
      ind_rd_q    <= rd_go && sel_data;
      ind_cap_q   <= ind_rd_q;
      if (wr_go && sel_data) ind_wdata_q <= wr_byte;
    end
  end

  assign IND_ADDR  = index_q;
  assign IND_WR    = ind_wr_q;
  assign IND_RD    = ind_rd_q;
  assign IND_WDATA = ind_wdata_q;

  // frame into the switch: one beat per host write, held until taken
  // limitation: the host must pace frame writes slower than the core takes beats
  frame_pos_s  in_pos_q;
  frame_pos_s  in_pos_n;
  frame_beat_s in_beat_q;
  logic        in_valid_q;
  wire         in_take = wr_go && sel_frame && !in_valid_q;  // writes while busy are dropped

  assign in_pos_n = frame_step(in_pos_q, sync2_q.wdata, wide);

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      in_pos_q   <= '0;
      in_beat_q  <= '0;
      in_valid_q <= 1'b0;
    end else begin
      if (in_take) begin
        in_pos_q   <= in_pos_n;
        in_beat_q  <= '{data: sync2_q.wdata, wide: wide,
                        hdr:  in_pos_q.count < HDR_BYTES,
                        sof:  in_pos_q.count == CNT_RESET,
                        eof:  frame_ends(in_pos_q, in_pos_n)};
        in_valid_q <= 1'b1;
      end else if (FRM_IN_READY) begin
        in_valid_q <= 1'b0;
      end
    end
  end

  assign FRM_IN_VALID = in_valid_q;
  assign FRM_IN       = in_beat_q;

  // frame out of the switch: host read pops one beat
  frame_pos_s out_pos_q;
  frame_pos_s out_pos_n;
  wire        out_pop = rd_go && sel_frame && FRM_OUT_VALID;

  assign out_pos_n     = frame_step(out_pos_q, FRM_OUT.data, wide);
  assign FRM_OUT_READY = out_pop;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) out_pos_q <= '0;
    else if (out_pop) out_pos_q <= out_pos_n;
  end

  // read data back to the pins; narrow mode keeps upper byte zero
  // a frame read with nothing waiting leaves the previous word on the pins
  logic [HOST_DW-1:0] rdata_q;
  logic               oe_q;
  wire  [HOST_DW-1:0] frame_rd = wide ? FRM_OUT.data : {8'h00, FRM_OUT.data[7:0]};

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      rdata_q <= DATA_RESET;
      oe_q    <= 1'b0;
    end else begin
      oe_q <= rd_now;
      if (ind_cap_q)    rdata_q <= {8'h00, IND_RDATA};
      else if (out_pop) rdata_q <= frame_rd;
    end
  end

  assign HOST_DATA_O  = rdata_q;
  assign HOST_DATA_OE = oe_q;

endmodule : host_port

// ---- host_port_pkg.sv ----
// constants and carrier types for the indirect-access host port
// assumes one 200 MHz clock; host pins arrive asynchronously and are synchronised in the port
package host_port_pkg;

  localparam int unsigned HOST_AW   = 3;
  localparam int unsigned HOST_DW   = 16;
  localparam int unsigned IND_AW    = 16;
  localparam int unsigned IND_DW    = 8;
  localparam int unsigned FCNT_W    = 16;

  // direct port addresses
  localparam logic [HOST_AW-1:0] OFS_ADDR_LOW  = 3'h0;
  localparam logic [HOST_AW-1:0] OFS_ADDR_HIGH = 3'h1;
  localparam logic [HOST_AW-1:0] OFS_DATA_PORT = 3'h2;
  localparam logic [HOST_AW-1:0] OFS_FRAME     = 3'h3;

  // frame layout: status header then payload padded to whole groups
  localparam logic [FCNT_W-1:0] HDR_BYTES   = 16'h0008;
  localparam logic [FCNT_W-1:0] PAD_MASK    = 16'h0007;
  localparam logic [FCNT_W-1:0] SIZE_BYTE0  = 16'h0000;
  localparam logic [FCNT_W-1:0] SIZE_BYTE1  = 16'h0001;
  localparam logic [FCNT_W-1:0] STEP_NARROW = 16'h0001;
  localparam logic [FCNT_W-1:0] STEP_WIDE   = 16'h0002;
  localparam logic [FCNT_W-1:0] CNT_RESET   = 16'h0000;
  localparam logic [IND_AW-1:0] ADDR_RESET  = 16'h0000;
  localparam logic [HOST_DW-1:0] DATA_RESET = 16'h0000;

  // host pins as seen through the synchroniser
  typedef struct packed {
    logic               cs_n;
    logic               rd_n;
    logic               wr_n;
    logic [HOST_AW-1:0] addr;
    logic [HOST_DW-1:0] wdata;
  } host_pins_s;

  // one beat of frame data between port and switch core
  typedef struct packed {
    logic [HOST_DW-1:0] data;   // low byte first; high byte valid when wide
    logic               wide;
    logic               hdr;    // beat lies inside the status header
    logic               sof;
    logic               eof;
  } frame_beat_s;

  // frame position tracker state
  typedef struct packed {
    logic [FCNT_W-1:0] count;
    logic [FCNT_W-1:0] size;
  } frame_pos_s;

endpackage : host_port_pkg

// ---- host_port_checker.sv ----
// checker for the host port: index, data port and frame framing
// assumes host strobes are held well past the synchroniser delay
`timescale 1ns/1ps
module host_port_checker
  import host_port_pkg::*;
(
  input wire logic               CLOCK,
  input wire logic               RST,
  input wire logic               WIDE_MODE,
  input wire logic               HOST_RD_N,
  input wire logic [HOST_AW-1:0] HOST_ADDR,
  input wire logic [HOST_DW-1:0] HOST_DATA_I,
  input wire logic [HOST_DW-1:0] HOST_DATA_O,
  input wire logic               HOST_DATA_OE,
  input wire logic [IND_AW-1:0]  IND_ADDR,
  input wire logic               IND_WR,
  input wire logic               IND_RD,
  input wire logic [IND_DW-1:0]  IND_WDATA,
  input wire logic [IND_DW-1:0]  IND_RDATA,
  input wire logic               FRM_IN_VALID,
  input wire frame_beat_s        FRM_IN,
  input wire logic               FRM_IN_READY,
  input wire logic               FRM_OUT_VALID,
  input wire logic               FRM_OUT_READY
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  logic [FCNT_W-1:0] bytes_q;
  wire               beat = FRM_IN_VALID && FRM_IN_READY;
  wire [FCNT_W-1:0]  step = FRM_IN.wide ? STEP_WIDE : STEP_NARROW;
  logic [IND_AW-1:0] addr_prev_q;
  wire               moved = IND_ADDR != addr_prev_q;
  // byte position within the frame handed to the core
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) bytes_q <= CNT_RESET;
    else if (beat) bytes_q <= FRM_IN.eof ? CNT_RESET : bytes_q + step;
  end
  // index as it stood one clock earlier, to spot a change
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) addr_prev_q <= ADDR_RESET;
    else     addr_prev_q <= IND_ADDR;
  end
  // the strobe is held long, so three clocks back always sees the write
  a_low_wide: assert property (moved && WIDE_MODE && $past(HOST_ADDR, 3) == OFS_ADDR_LOW
    |-> IND_ADDR == $past(HOST_DATA_I, 3)) else $error("wide index wrong");
  a_low_narrow: assert property (moved && !WIDE_MODE && $past(HOST_ADDR, 3) == OFS_ADDR_LOW
    |-> IND_ADDR == {$past(IND_ADDR[15:8]), $past(HOST_DATA_I[7:0], 3)}) else $error("low index wrong");
  a_high_index: assert property (moved && $past(HOST_ADDR, 3) == OFS_ADDR_HIGH
    |-> !WIDE_MODE && IND_ADDR == {$past(HOST_DATA_I[7:0], 3), $past(IND_ADDR[7:0])}) else $error("high index");
  a_data_write: assert property (IND_WR
    |-> $past(HOST_ADDR, 3) == OFS_DATA_PORT && IND_WDATA == $past(HOST_DATA_I[7:0], 3)) else $error("data write");
  a_data_read: assert property ($past(IND_RD, 2)
    |-> HOST_DATA_O == {8'h00, $past(IND_RDATA)}) else $error("data read");
  a_oe_read: assert property (HOST_DATA_OE
    |-> $past(HOST_RD_N, 3) == 1'b0) else $error("pins driven without read");
  a_out_pop: assert property (FRM_OUT_READY |-> FRM_OUT_VALID && HOST_ADDR == OFS_FRAME) else $error("frame pop");
  a_hdr_first: assert property (beat |-> FRM_IN.hdr == (bytes_q < HDR_BYTES)) else $error("header beat");
  a_pad_end: assert property (beat && FRM_IN.eof |-> ((bytes_q + step) & PAD_MASK) == 0) else $error("pad");
endmodule : host_port_checker

bind host_port host_port_checker u_chk (.CLOCK, .RST, .WIDE_MODE, .HOST_RD_N, .HOST_ADDR, .HOST_DATA_I, .HOST_DATA_O,
  .IND_ADDR, .IND_WR, .IND_RD, .IND_WDATA, .IND_RDATA, .FRM_IN_VALID, .FRM_IN, .FRM_IN_READY, .FRM_OUT_VALID,
  .FRM_OUT_READY, .HOST_DATA_OE);

// ---- host_cpu.sv ----
// host processor model: one strobed access at a time on the port pins
// assumes the port synchronises strobes, so they are held for many clocks
`timescale 1ns/1ps
module host_cpu
  import host_port_pkg::*;
(
  input  wire logic [HOST_DW-1:0] RDATA,
  input  wire logic               CLOCK,
  output host_pins_s              PINS
);
  initial PINS = '{1'b1, 1'b1, 1'b1, 3'h0, 16'h0000};
  // index is written before data port use; data lines toggle once released
  task automatic access(input logic wr, input logic [HOST_AW-1:0] a, input logic [HOST_DW-1:0] d,
                        output logic [HOST_DW-1:0] q);
    @(posedge CLOCK);
    PINS <= '{1'b0, wr, !wr, a, d};
    repeat (10) @(posedge CLOCK);
    q = RDATA;
    PINS <= '{1'b1, 1'b1, 1'b1, a, ~d};
    repeat (4) @(posedge CLOCK);
  endtask : access
endmodule : host_cpu

// ---- indirect_access_host_port_test.sv ----
// testbench: host model drives the pins, a small register file answers the core side
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; $display("BAD %s %h %h", n, e, g); end end
module indirect_access_host_port_test;
  import host_port_pkg::*;
  logic               CLOCK = 0, RST = 1, WIDE_MODE = 0, FRM_OUT_VALID = 0, ind_wr, ind_rd, frm_in_valid;
  logic               frm_in_ready = 0, frm_out_ready, host_oe;
  host_pins_s         pins;
  frame_beat_s        frm_in, frm_out = '0;
  logic [HOST_DW-1:0] data_o, q;
  logic [IND_AW-1:0]  ind_addr;
  logic [IND_DW-1:0]  ind_wdata, ind_rdata = 8'h00, mem [16];
  int                 fails = 0, checked = 0, beats = 0, eof_at = 0, hdrs = 0, pops = 0, oe_cycles = 0;
  always #2.5 CLOCK = ~CLOCK;
  host_cpu cpu (.RDATA(data_o), .CLOCK, .PINS(pins));
  host_port DUT (.CLOCK, .RST, .WIDE_MODE, .HOST_CS_N(pins.cs_n), .HOST_RD_N(pins.rd_n), .HOST_WR_N(pins.wr_n),
    .HOST_ADDR(pins.addr), .HOST_DATA_I(pins.wdata), .HOST_DATA_O(data_o), .HOST_DATA_OE(host_oe),
    .IND_ADDR(ind_addr), .IND_WR(ind_wr), .IND_RD(ind_rd), .IND_WDATA(ind_wdata), .IND_RDATA(ind_rdata),
    .FRM_IN_VALID(frm_in_valid), .FRM_IN(frm_in), .FRM_IN_READY(frm_in_ready), .FRM_OUT_VALID, .FRM_OUT(frm_out),
    .FRM_OUT_READY(frm_out_ready));
  // core accepts frame beats only on every other clock, so a beat may have to wait
  always @(posedge CLOCK) frm_in_ready <= ~frm_in_ready;
  // indirect register space and frame beat count on the core side
  always @(posedge CLOCK) begin
    if (ind_wr) mem[ind_addr[3:0]] <= ind_wdata;
    if (ind_rd) ind_rdata <= mem[ind_addr[3:0]];
    if (frm_out_ready) pops++;
    if (host_oe) oe_cycles++;
    if (frm_in_valid && frm_in_ready) begin
      beats++;
      hdrs += frm_in.hdr;
      if (frm_in.eof) eof_at = beats;
    end
  end
  task automatic index_narrow;
    cpu.access(1'b1, OFS_ADDR_LOW, 16'hff34, q);
    cpu.access(1'b1, OFS_ADDR_HIGH, 16'h0005, q);
    `CHK("index", 16'h0534, ind_addr)
    cpu.access(1'b1, OFS_DATA_PORT, 16'h005a, q);
    `CHK("ind wr", 8'h5a, mem[4])
    cpu.access(1'b0, OFS_DATA_PORT, 16'h0000, q);
    `CHK("ind rd", 8'h5a, q[7:0])
    `CHK("held", 16'h0534, ind_addr)
  endtask : index_narrow
  // size three pads to eight payload bytes behind the eight header bytes
  task automatic frame_in;
    for (int i = 0; i < 16; i++) cpu.access(1'b1, OFS_FRAME, i == 0 ? 16'h0003 : i == 1 ? 16'h0000 : 16'h00a5, q);
    `CHK("eof at", 16, eof_at)
    `CHK("hdr beats", 8, hdrs)
  endtask : frame_in
  task automatic index_wide;
    @(posedge CLOCK) WIDE_MODE <= 1'b1;
    cpu.access(1'b1, OFS_ADDR_LOW, 16'habc7, q);
    `CHK("wide index", 16'habc7, ind_addr)
    cpu.access(1'b1, OFS_ADDR_HIGH, 16'h0011, q);
    `CHK("high unused", 16'habc7, ind_addr)
  endtask : index_wide
  // wide beats carry two bytes: size five pads to eight, sixteen bytes in eight beats
  task automatic frame_in_wide;
    for (int i = 0; i < 8; i++) cpu.access(1'b1, OFS_FRAME, i == 0 ? 16'h0005 : 16'h5aa5, q);
    `CHK("wide eof at", 24, eof_at)
    `CHK("wide hdr beats", 12, hdrs)
  endtask : frame_in_wide
  // the pins are driven for as long as the read strobe stands, ten clocks per read
  task automatic frame_out;
    @(posedge CLOCK);
    frm_out <= '{16'hbeef, 1'b1, 1'b1, 1'b1, 1'b0};
    FRM_OUT_VALID <= 1'b1;
    cpu.access(1'b0, OFS_FRAME, 16'h0000, q);
    `CHK("frame rd", 16'hbeef, q)
    `CHK("frame pop", 1, pops)
    `CHK("oe cycles", 20, oe_cycles)
  endtask : frame_out
  task automatic finish_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  initial begin
    repeat (5) @(posedge CLOCK);
    RST <= 1'b0;
    index_narrow();
    frame_in();
    index_wide();
    frame_in_wide();
    frame_out();
    finish_test();
  end
  // about thirty accesses of fifteen clocks each; far beyond that is a hang
  initial begin
    repeat (20000) @(posedge CLOCK);
    fails++;
    finish_test();
  end
endmodule : indirect_access_host_port_test
